// [rtl/tsf_consts.svh]
// register offsets, reset values and field positions of the temperature status block
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH

`define TSF_ADDR_LOW_LIMIT 8'h30
`define TSF_ADDR_HIGH_FLAGS 8'h44
`define TSF_ADDR_OT_FLAGS 8'h45
`define TSF_ADDR_DIODE_FLAGS 8'h46
`define TSF_ADDR_LOW_FLAGS 8'h47
`define TSF_ADDR_COMP_EN 8'h4a
`define TSF_ADDR_ALERT_MASK 8'h4c
`define TSF_ADDR_OT_MASK 8'h4d

`define TSF_RST_LOW_LIMIT 8'h00
`define TSF_RST_COMP_EN 7'h00
`define TSF_RST_MASK 8'h00
`define TSF_RST_FLAGS 8'h00
`define TSF_UNMAPPED_DATA 8'h00

`define TSF_BIT_LOCAL 6
`define TSF_BIT_CH7 7
`define TSF_DIODE_RSVD_BIT 7

`endif

// [rtl/tsf_pkg.sv]
// types and channel-to-bit mapping shared by the temperature status block
package tsf_pkg;
	typedef logic [7:0] tsf_byte_t;

	// channel 0 is local, 1..7 remote; returns its status bit position
	function automatic int tsf_bit_of(input int ch);
		if (ch == 0) begin
			return 6;
		end else if (ch == 7) begin
			return 7;
		end
		return ch - 1;
	endfunction : tsf_bit_of
endpackage : tsf_pkg

// [rtl/tsf_chan_cmp.sv]
// per-channel limit comparison, refreshed on each conversion result
`timescale 1ns/1ps
module tsf_chan_cmp #(
	parameter int TEMP_W = 8
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// conversion result and limits
	input wire logic update_i,
	input wire logic [TEMP_W-1:0] temp_i,
	input wire logic [TEMP_W-1:0] high_limit_i,
	input wire logic [TEMP_W-1:0] ot_limit_i,
	input wire logic [TEMP_W-1:0] low_limit_i,
	// flags
	output logic high_o,
	output logic ot_o,
	output logic low_o
);
	// flags follow the latest result, so they clear once the condition is gone
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			high_o <= 1'b0;
			ot_o <= 1'b0;
			low_o <= 1'b0;
		end else if (update_i) begin
			high_o <= temp_i > high_limit_i;
			ot_o <= temp_i > ot_limit_i;
			low_o <= temp_i < low_limit_i;
		end
	end

	a_low_compare: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		update_i |=> low_o == ($past(temp_i) < $past(low_limit_i)))
		else $error("low flag does not match last comparison");
endmodule : tsf_chan_cmp

// [rtl/tsf_status_flags.sv]
// status flags, shared low limit, masks and compensation enables of an eight-channel temperature monitor
`timescale 1ns/1ps
`include "tsf_consts.svh"
// Functional notes
// - High-alarm bit 6 is set while the local temperature is above its high-alarm limit.
// - Each remote channel sets its high-alarm bit above its limit, channel 7 on bit 7 and 6..1 on bits 5..0.
// - Over-temperature bit 6 becomes one when the local temperature exceeds its over-temperature limit.
// - Each remote channel sets its over-temperature bit, channel 7 on bit 7 and 6..1 on bits 5..0.
// - Remote channels 2..7 set diode-fault bit channel-1 when the diode is open or the anode sits at supply.
// - Diode-fault bit 0 is set when channel 1's anode and cathode are open or shorted together.
// - The diode-fault flags are readable at 0x46.
// - A channel's bit at 0x47 is set when its temperature is below the shared low limit at 0x30.
// - Low-alarm bit 7 belongs to remote channel 7.
// - Low-alarm bit 6 is the local channel and bits 5..0 are remote channels 6..1.
// - A read/write register at 0x4a enables series-resistance compensation per remote channel.
// - Compensation bit channel-1 serves channels 1..7, bit 7 is ignored, and all clear at reset.
// - A set mask bit suppresses its channel's high-alarm interrupt; mapping as the status bits, reset zero.
module tsf_status_flags
	import tsf_pkg::*;
#(
	parameter int N_CH = 8,
	parameter int TEMP_W = 8
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// byte register port, one command per write-byte or read-byte transaction
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_cmd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// conversion results, channel 0 local, 1..7 remote
	input wire logic [N_CH-1:0] temp_valid_i,
	input wire logic [N_CH*TEMP_W-1:0] temp_i,
	input wire logic [N_CH*TEMP_W-1:0] high_limit_i,
	input wire logic [N_CH*TEMP_W-1:0] ot_limit_i,
	// remote diode sense, index is channel-1
	input wire logic [N_CH-2:0] remote_diode_open_i,
	input wire logic [N_CH-2:0] remote_diode_anode_at_supply_i,
	input wire logic remote_diode_short_i,
	// compensation enables, index is channel-1
	output logic [N_CH-2:0] comp_enable_o,
	// open-drain alarm pins, output value and enable
	output logic alert_out_o,
	output logic alert_oe_o,
	output logic overtemp_alarm_output_o,
	output logic overtemp_alarm_output_oe_o
);
	logic [7:0] high_alarm_flags;
	logic [7:0] overtemp_flags;
	logic [7:0] low_alarm_flags;
	logic [7:0] diode_fault_flags;
	logic [7:0] shared_low_alarm_limit;
	logic [6:0] series_resistance_comp_enable;
	logic [7:0] alert_mask;
	logic [7:0] ot_mask;
	logic [7:0] next_rdata;

	// elaboration guard: the bit mapping is fixed to eight byte-wide channels
	if (N_CH != 8 || TEMP_W != 8) begin : g_bad_size
		$error("tsf_status_flags serves eight channels of byte-wide data only");
	end

	// per-channel comparators, placed on the documented status bit
	for (genvar g = 0; g < N_CH; g++) begin : g_ch
		tsf_chan_cmp #(
			.TEMP_W(TEMP_W)
		) u_cmp (
			.ref_clk_i(ref_clk_i),
			.reset_i(reset_i),
			.update_i(temp_valid_i[g]),
			.temp_i(temp_i[g*TEMP_W +: TEMP_W]),
			.high_limit_i(high_limit_i[g*TEMP_W +: TEMP_W]),
			.ot_limit_i(ot_limit_i[g*TEMP_W +: TEMP_W]),
			.low_limit_i(shared_low_alarm_limit),
			.high_o(high_alarm_flags[tsf_bit_of(g)]),
			.ot_o(overtemp_flags[tsf_bit_of(g)]),
			.low_o(low_alarm_flags[tsf_bit_of(g)])
		);
	end

	// diode faults refresh with each remote conversion
	for (genvar r = 1; r < N_CH; r++) begin : g_diode
		always_ff @(posedge ref_clk_i) begin
			if (reset_i) begin
				diode_fault_flags[r-1] <= 1'b0;
			end else if (temp_valid_i[r]) begin
				if (r == 1) begin
					diode_fault_flags[r-1] <= remote_diode_open_i[r-1] | remote_diode_short_i;
				end else begin
					diode_fault_flags[r-1] <= remote_diode_open_i[r-1] | remote_diode_anode_at_supply_i[r-1];
				end
			end
		end
	end
	assign diode_fault_flags[`TSF_DIODE_RSVD_BIT] = 1'b0;

	// writable registers; writes to flag registers are dropped
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			shared_low_alarm_limit <= `TSF_RST_LOW_LIMIT;
			series_resistance_comp_enable <= `TSF_RST_COMP_EN;
			alert_mask <= `TSF_RST_MASK;
			ot_mask <= `TSF_RST_MASK;
		end else if (reg_wr_i) begin
			case (reg_cmd_i)
				`TSF_ADDR_LOW_LIMIT: shared_low_alarm_limit <= reg_wdata_i;
				`TSF_ADDR_COMP_EN: series_resistance_comp_enable <= reg_wdata_i[6:0];
				`TSF_ADDR_ALERT_MASK: alert_mask <= reg_wdata_i;
				`TSF_ADDR_OT_MASK: ot_mask <= reg_wdata_i;
				default: ;
			endcase
		end
	end
	assign comp_enable_o = series_resistance_comp_enable;

	// read mux; unmapped commands answer zero
	always_comb begin
		case (reg_cmd_i)
			`TSF_ADDR_LOW_LIMIT: next_rdata = shared_low_alarm_limit;
			`TSF_ADDR_HIGH_FLAGS: next_rdata = high_alarm_flags;
			`TSF_ADDR_OT_FLAGS: next_rdata = overtemp_flags;
			`TSF_ADDR_DIODE_FLAGS: next_rdata = diode_fault_flags;
			`TSF_ADDR_LOW_FLAGS: next_rdata = low_alarm_flags;
			`TSF_ADDR_COMP_EN: next_rdata = {1'b0, series_resistance_comp_enable};
			`TSF_ADDR_ALERT_MASK: next_rdata = alert_mask;
			`TSF_ADDR_OT_MASK: next_rdata = ot_mask;
			default: next_rdata = `TSF_UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// alarm pins pull low; masking only gates the pin, never the status bit
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			alert_oe_o <= 1'b0;
			overtemp_alarm_output_oe_o <= 1'b0;
		end else begin
			alert_oe_o <= |(high_alarm_flags & ~alert_mask);
			overtemp_alarm_output_oe_o <= |(overtemp_flags & ~ot_mask);
		end
	end
	assign alert_out_o = 1'b0;
	assign overtemp_alarm_output_o = 1'b0;

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	a_local_high: assert property (temp_valid_i[0] |=>
		high_alarm_flags[`TSF_BIT_LOCAL] == ($past(temp_i[TEMP_W-1:0]) > $past(high_limit_i[TEMP_W-1:0])))
		else $error("local high flag wrong");
	a_ch7_high: assert property (temp_valid_i[7] |=>
		high_alarm_flags[`TSF_BIT_CH7] == ($past(temp_i[8*TEMP_W-1 -: TEMP_W]) > $past(high_limit_i[8*TEMP_W-1 -: TEMP_W])))
		else $error("channel 7 high flag wrong");
	a_ch1_high: assert property (temp_valid_i[1] |=>
		high_alarm_flags[0] == ($past(temp_i[2*TEMP_W-1 -: TEMP_W]) > $past(high_limit_i[2*TEMP_W-1 -: TEMP_W])))
		else $error("channel 1 high flag wrong");
	a_local_ot: assert property (temp_valid_i[0] |=>
		overtemp_flags[`TSF_BIT_LOCAL] == ($past(temp_i[TEMP_W-1:0]) > $past(ot_limit_i[TEMP_W-1:0])))
		else $error("local overtemp flag wrong");
	a_ch6_ot: assert property (temp_valid_i[6] |=>
		overtemp_flags[5] == ($past(temp_i[7*TEMP_W-1 -: TEMP_W]) > $past(ot_limit_i[7*TEMP_W-1 -: TEMP_W])))
		else $error("channel 6 overtemp flag wrong");
	a_ch1_diode: assert property (temp_valid_i[1] |=>
		diode_fault_flags[0] == ($past(remote_diode_open_i[0]) | $past(remote_diode_short_i)))
		else $error("channel 1 diode fault wrong");
	a_ch7_diode: assert property (temp_valid_i[7] |=>
		diode_fault_flags[6] == ($past(remote_diode_open_i[6]) | $past(remote_diode_anode_at_supply_i[6])))
		else $error("channel 7 diode fault wrong");
	a_diode_read: assert property (reg_rd_i && reg_cmd_i == `TSF_ADDR_DIODE_FLAGS |=>
		reg_rvalid_o && reg_rdata_o == $past(diode_fault_flags) && !reg_rdata_o[7])
		else $error("diode fault read wrong");
	a_comp_write: assert property (reg_wr_i && reg_cmd_i == `TSF_ADDR_COMP_EN |=>
		comp_enable_o == $past(reg_wdata_i[6:0]))
		else $error("compensation enable not written");
	a_alert_mask: assert property ((high_alarm_flags & ~alert_mask) == 8'h00 |=> !alert_oe_o)
		else $error("masked high alarm drives alert pin");
	a_flag_clears: assert property (temp_valid_i[0] && temp_i[TEMP_W-1:0] < shared_low_alarm_limit
		##1 temp_valid_i[0] && temp_i[TEMP_W-1:0] >= shared_low_alarm_limit |=> !low_alarm_flags[`TSF_BIT_LOCAL])
		else $error("low flag did not clear");

	// low-alarm mapping, local and channel 7 sit off the plain channel-1 order
	a_local_low: assert property (temp_valid_i[0] |=>
		low_alarm_flags[`TSF_BIT_LOCAL] == ($past(temp_i[TEMP_W-1:0]) < $past(shared_low_alarm_limit)))
		else $error("local low flag wrong");
	a_ch7_low: assert property (temp_valid_i[7] |=>
		low_alarm_flags[`TSF_BIT_CH7] == ($past(temp_i[8*TEMP_W-1 -: TEMP_W]) < $past(shared_low_alarm_limit)))
		else $error("channel 7 low flag wrong");

	// register port writes and read-back
	a_low_read: assert property (reg_rd_i && reg_cmd_i == `TSF_ADDR_LOW_FLAGS |=>
		reg_rvalid_o && reg_rdata_o == $past(low_alarm_flags))
		else $error("low flag read wrong");
	a_limit_write: assert property (reg_wr_i && reg_cmd_i == `TSF_ADDR_LOW_LIMIT |=>
		shared_low_alarm_limit == $past(reg_wdata_i))
		else $error("shared low limit not written");
	a_comp_rsvd: assert property (reg_rd_i && reg_cmd_i == `TSF_ADDR_COMP_EN |=>
		reg_rvalid_o && !reg_rdata_o[7] && reg_rdata_o[6:0] == $past(comp_enable_o))
		else $error("compensation enable read wrong");
	a_unmapped_read: assert property (reg_rd_i && reg_cmd_i == 8'h00 |=>
		reg_rvalid_o && reg_rdata_o == `TSF_UNMAPPED_DATA)
		else $error("unmapped read not zero");
	a_rvalid_idle: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("read answer without read");

	// alarm pins follow the unmasked flags one cycle later
	a_alert_drive: assert property ((high_alarm_flags & ~alert_mask) != 8'h00 |=> alert_oe_o)
		else $error("unmasked high alarm not on alert pin");
	a_ot_pin: assert property ((overtemp_flags & ~ot_mask) == 8'h00 |=> !overtemp_alarm_output_oe_o)
		else $error("masked overtemp alarm drives pin");
endmodule : tsf_status_flags

// [testbench/tsf_host.sv]
// host model issuing write-byte and read-byte transactions on the register port
`timescale 1ns/1ps
module tsf_host (
	// clock
	input wire logic ref_clk_i,
	// byte register port
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_cmd_o,
	output logic [7:0] reg_wdata_o
);
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_cmd_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// single bytes only; strobe drops for a cycle between transactions
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_o <= 1'b1;
		reg_cmd_o <= c;
		reg_wdata_o <= d;
		@(posedge ref_clk_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] c);
		@(posedge ref_clk_i);
		reg_rd_o <= 1'b1;
		reg_cmd_o <= c;
		@(posedge ref_clk_i);
		reg_rd_o <= 1'b0;
		reg_cmd_o <= ~c;
	endtask : rd
endmodule : tsf_host

// [testbench/temp_threshold_status_flags_tb.sv]
// self-checking bench for the temperature status flags
`timescale 1ns/1ps
module temp_threshold_status_flags_tb;
	import tsf_pkg::*;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr, rd, rvalid, dshort, a_out, a_oe, o_out, o_oe;
	logic [7:0] cmd, wdata, rdata, tv, low, am, om, eh, eo, el, ed, t, h, o;
	logic [63:0] temp, hl, ol;
	logic [6:0] dopen, dsup, comp, rop, rsu, cw;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	int p;
	int seed = 32'h162315cd;
	tsf_byte_t exp_q[$];
	tsf_host tsf_host_i (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_cmd_o(cmd), .reg_wdata_o(wdata));
	tsf_status_flags tsf_status_flags_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_cmd_i(cmd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .temp_valid_i(tv),
		.temp_i(temp), .high_limit_i(hl), .ot_limit_i(ol), .remote_diode_open_i(dopen),
		.remote_diode_anode_at_supply_i(dsup), .remote_diode_short_i(dshort), .comp_enable_o(comp),
		.alert_out_o(a_out), .alert_oe_o(a_oe), .overtemp_alarm_output_o(o_out), .overtemp_alarm_output_oe_o(o_oe));
	initial begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	task automatic conclude();
		if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : check
	task automatic check_pin(input string what, input logic e, input logic s);
		check(what, {7'h00, e}, {7'h00, s});
	endtask : check_pin
	task automatic check_comp(input logic [6:0] e);
		check("comp_enable", {1'b0, e}, {1'b0, comp});
	endtask : check_comp
	task automatic rd_exp(input logic [7:0] c, input logic [7:0] e);
		exp_q.push_back(e);
		tsf_host_i.rd(c);
	endtask : rd_exp
	// oldest note is matched to each read answer
	always @(posedge ref_clk_i) begin
		if (rvalid === 1'b1) check("rdata", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, rdata);
	end
	// ceiling well above the roughly 720 cycles the sequence needs
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		tv = 8'h00;
		temp = '0;
		hl = '0;
		ol = '0;
		dopen = '0;
		dsup = '0;
		dshort = 1'b0;
		repeat (10) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd_exp(8'h30, 8'h00);
		rd_exp(8'h4a, 8'h00);
		for (int a = 8'h44; a <= 8'h47; a++) rd_exp(8'(a), 8'h00);
		rd_exp(8'h00, 8'h00);
		tsf_host_i.wr(8'h4a, 8'hff);
		rd_exp(8'h4a, 8'h7f);
		check_comp(7'h7f);
		for (int it = 0; it < 24; it++) begin
			low = 8'($random(seed));
			am = 8'($random(seed));
			om = 8'($random(seed));
			tsf_host_i.wr(8'h30, low);
			tsf_host_i.wr(8'h4c, am);
			tsf_host_i.wr(8'h4d, om);
			tsf_host_i.wr(8'h44, 8'hff);
			cw = 7'($random(seed));
			tsf_host_i.wr(8'h4a, {it[0], cw});
			// first pass puts every value on its limit: strict compares leave all high, overtemp and low flags clear
			for (int ch = 0; ch < 8; ch++) begin
				t = (it == 0) ? low : 8'($random(seed));
				h = (it == 0) ? t : 8'($random(seed));
				o = (it == 0) ? t : 8'($random(seed));
				temp[8*ch +: 8] <= t;
				hl[8*ch +: 8] <= h;
				ol[8*ch +: 8] <= o;
				p = (ch == 0) ? 6 : (ch == 7) ? 7 : ch - 1;
				eh[p] = t > h;
				eo[p] = t > o;
				el[p] = t < low;
			end
			rop = 7'($random(seed));
			rsu = 7'($random(seed));
			dopen <= rop;
			dsup <= rsu;
			dshort <= it[0];
			ed = {1'b0, rop[6:1] | rsu[6:1], rop[0] | it[0]};
			@(posedge ref_clk_i);
			tv <= 8'hff;
			@(posedge ref_clk_i);
			tv <= 8'h00;
			rd_exp(8'h44, eh);
			rd_exp(8'h45, eo);
			rd_exp(8'h46, ed);
			rd_exp(8'h47, el);
			rd_exp(8'h30, low);
			rd_exp(8'h4a, {1'b0, cw});
			rd_exp(8'h4c, am);
			rd_exp(8'h4d, om);
			check_comp(cw);
			check_pin("alert_oe", |(eh & ~am), a_oe);
			check_pin("overtemp_oe", |(eo & ~om), o_oe);
			check_pin("alert_out", 1'b0, a_out);
			check_pin("overtemp_out", 1'b0, o_out);
		end
		// local result below the limit, then level with it: flag must drop, others stand
		tsf_host_i.wr(8'h30, 8'h80);
		temp[7:0] <= 8'h10;
		tv <= 8'h01;
		@(posedge ref_clk_i);
		temp[7:0] <= 8'h80;
		@(posedge ref_clk_i);
		tv <= 8'h00;
		rd_exp(8'h47, el & 8'hbf);
		// reset in mid-run clears enables and flags
		@(posedge ref_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		check_comp(7'h00);
		check_pin("alert_oe", 1'b0, a_oe);
		rd_exp(8'h4a, 8'h00);
		rd_exp(8'h47, 8'h00);
		repeat (4) @(posedge ref_clk_i);
		check("pending", 8'h00, 8'(exp_q.size()));
		conclude();
	end
endmodule : temp_threshold_status_flags_tb
